// file: clk_params.svh
// Register offsets, field positions, reset values and start-up counts
`ifndef CLK_PARAMS_SVH
`define CLK_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_MODE   8'h00
`define OFS_CFG    8'h01
`define OFS_STAT   8'h02
`define OFS_IRQS   8'h03
`define OFS_IRQM   8'h04
`define OFS_STATE  8'h05

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODE_DIV_MSB   7
`define MODE_DIV_LSB   5
`define MODE_QUICK     4
`define MODE_LS_RDY    3
`define MODE_HS_RDY    2
`define MODE_IDLE      1
`define MODE_HL        0
`define CFG_KEEP       0
`define CFG_VDET       1
`define CFG_WDT_EN     2
`define CFG_WDT_SUB    3
`define CFG_OSC_LSB    4
`define CFG_OSC_MSB    5
`define STAT_PDF       0
`define STAT_TO        1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MODE_RST   8'h03
`define CFG_RST    8'h00
`define STAT_RST   2'h0
`define IRQ_RST    3'h0

// ----------------------------------------
// Start-up counts in oscillator cycles
// ----------------------------------------
`define XTAL_START 11'h400
`define RC_START   11'h010
`define LS_START   11'h002

`endif

// file: clk_pkg.sv
// Types shared by the clock and power-mode controller
package clk_pkg;
	typedef enum logic [2:0] {
		ST_RUN       = 3'h0,
		ST_IDLE_STOP = 3'h1,
		ST_IDLE_RUN  = 3'h3,
		ST_DEEP      = 3'h2,
		ST_STOP_SUB  = 3'h6,
		ST_WAKE      = 3'h7,
		ST_FAST      = 3'h5
	} pwr_state_t;
	typedef enum logic [1:0] {
		OSC_XTAL  = 2'h0,
		OSC_EXTRC = 2'h1,
		OSC_INTRC = 2'h2
	} hs_osc_t;
endpackage : clk_pkg

// file: clk_power_ctrl.sv
// System clock selection, low-power mode and wake-up controller
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "clk_params.svh"

module clk_power_ctrl
	import clk_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	input  wire logic       haltReq,
	input  wire logic       wakeReq,
	input  wire logic       wdtTimeout,
	input  wire logic       hsOscPin,
	input  wire logic       lsOscPin,
	output logic            sysClk,
	output logic            wdtClk,
	output logic            subClk,
	output logic            cpuRun,
	output logic            hsOscEn,
	output logic            lsOscEn,
	output logic      [2:0] pwrState,
	output logic            irq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	pwr_state_t  state_reg;
	pwr_state_t  state_next;
	logic [7:0]  mode_reg;
	logic [5:0]  cfg_reg;
	logic [1:0]  stat_reg;
	logic [1:0]  stat_next;
	logic [2:0]  irqStat_reg;
	logic [2:0]  irqStat_next;
	logic [2:0]  irqMask_reg;
	logic [5:0]  div_reg;
	logic [2:0]  actSrc_reg;
	logic        gate_reg;
	logic [1:0]  sysDiv_reg;
	logic        hsRdyOld_reg;
	logic        lsRdyOld_reg;
	logic [7:0]  rdMux;
	logic        hsLvl;
	logic        hsRise;
	logic        lsLvl;
	logic        lsRise;
	logic        hsRdy;
	logic        lsRdy;
	logic [10:0] hsLimit;
	logic [2:0]  selSrc;
	logic [2:0]  wantSrc;
	logic        wantHs;
	logic        actLvl;
	logic        wantLvl;
	logic        sysRun;
	logic        hsNeed;
	logic        haltTaken;
	logic        quickOk;
	logic        wakeDone;
	logic        wdtOn;
	logic        wdtLvl;
	logic        sysRiseNext;
	logic        gateNext;
	logic [2:0]  evt;
	hs_osc_t     oscType;
	logic        wrMode;
	logic        wrCfg;
	logic        wrStat;
	logic        wrIrqS;
	logic        wrIrqM;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Source code: 0 slow clock, 1..6 fast/64..fast/2, 7 undivided fast
	function automatic logic [2:0] pickSrc(input logic hl, input logic [2:0] dv);
		if (hl)
			return 3'h7;
		else if (dv < 3'h2)
			return 3'h0;
		else
			return 3'(dv - 3'h1);
	endfunction : pickSrc

	function automatic logic srcLevel(input logic [2:0] src, input logic ls,
		input logic hs, input logic [5:0] dc);
		if (src == 3'h0)
			return ls;
		else if (src == 3'h7)
			return hs;
		else
			return dc[3'(3'h6 - src)];
	endfunction : srcLevel

	// ----------------------------------------
	// Oscillator inputs and start-up timers
	// ----------------------------------------
	osc_level_sync uHsSync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pinIn   (hsOscPin),
		.level   (hsLvl),
		.rise    (hsRise)
	);

	osc_level_sync uLsSync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pinIn   (lsOscPin),
		.level   (lsLvl),
		.rise    (lsRise)
	);

	assign oscType = hs_osc_t'(cfg_reg[`CFG_OSC_MSB:`CFG_OSC_LSB]);
	assign hsLimit = (oscType == OSC_XTAL) ? `XTAL_START : `RC_START;

	osc_ready_timer #(.W(11)) uHsTimer (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.run     (hsOscEn),
		.tick    (hsRise),
		.limit   (hsLimit),
		.ready   (hsRdy)
	);

	osc_ready_timer #(.W(11)) uLsTimer (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.run     (lsOscEn),
		.tick    (lsRise),
		.limit   (`LS_START),
		.ready   (lsRdy)
	);

	// ----------------------------------------
	// Mode state machine
	// ----------------------------------------
	assign selSrc    = pickSrc(mode_reg[`MODE_HL], mode_reg[`MODE_DIV_MSB:`MODE_DIV_LSB]);
	assign wantHs    = (selSrc != 3'h0);
	assign haltTaken = (state_reg == ST_RUN) & haltReq;
	// Only the crystal benefits; RC and slow sources start fast enough
	assign quickOk   = mode_reg[`MODE_QUICK] & wantHs & (oscType == OSC_XTAL);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (haltReq) begin
					if (mode_reg[`MODE_IDLE])
						state_next = cfg_reg[`CFG_KEEP] ? ST_IDLE_RUN : ST_IDLE_STOP;
					else if (cfg_reg[`CFG_VDET] | cfg_reg[`CFG_WDT_EN])
						state_next = ST_STOP_SUB;
					else
						state_next = ST_DEEP;
				end
			end
			ST_IDLE_RUN: begin
				if (wakeReq)
					state_next = ST_RUN;
			end
			ST_IDLE_STOP, ST_STOP_SUB: begin
				if (wakeReq)
					state_next = quickOk ? ST_FAST : ST_WAKE;
			end
			ST_DEEP: begin
				if (wakeReq)
					state_next = ST_WAKE;
			end
			ST_WAKE: begin
				if (wantHs ? hsRdy : lsRdy)
					state_next = ST_RUN;
			end
			ST_FAST: begin
				if (hsRdy)
					state_next = ST_RUN;
			end
			default: state_next = ST_RUN;
		endcase
	end

	// ----------------------------------------
	// Oscillator enables and run outputs
	// ----------------------------------------
	// Fast oscillator stays up until the glitch-free switch has closed its gate on it
	assign hsNeed  = wantHs & ((state_reg == ST_RUN) | (state_reg == ST_IDLE_RUN) |
		(state_reg == ST_WAKE) | (state_reg == ST_FAST));
	assign hsOscEn = hsNeed | (gate_reg & (actSrc_reg != 3'h0));
	assign lsOscEn = (state_reg != ST_DEEP);
	assign cpuRun  = (state_reg == ST_RUN) | ((state_reg == ST_FAST) & lsRdy);
	assign sysRun  = cpuRun | (state_reg == ST_IDLE_RUN);
	assign pwrState = state_reg;

	// ----------------------------------------
	// Glitch-free system clock switch
	// ----------------------------------------
	// During quick wake the substitute clock stands in for the crystal
	assign wantSrc = (state_reg == ST_FAST) ? 3'h0 : selSrc;
	assign actLvl  = srcLevel(actSrc_reg, lsLvl, hsLvl, div_reg);
	assign wantLvl = srcLevel(wantSrc, lsLvl, hsLvl, div_reg);
	// The gate only moves while the active source is low, so no runt pulse
	assign gateNext = actLvl ? gate_reg :
		(sysRun & (actSrc_reg == wantSrc));
	assign sysRiseNext = gate_reg & actLvl & ~sysClk;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_reg    <= 6'h00;
			actSrc_reg <= 3'h7;
			gate_reg   <= 1'b0;
			sysClk     <= 1'b0;
			sysDiv_reg <= 2'h0;
		end else begin
			if (hsRise)
				div_reg <= 6'(div_reg + 6'h01);
			if (!gate_reg && !gateNext && !wantLvl)
				actSrc_reg <= wantSrc;
			gate_reg <= gateNext;
			sysClk   <= gate_reg & actLvl;
			if (sysRiseNext)
				sysDiv_reg <= 2'(sysDiv_reg + 2'h1);
		end
	end

	// ----------------------------------------
	// Watchdog and substitute clocks
	// ----------------------------------------
	assign wdtLvl = cfg_reg[`CFG_WDT_SUB] ? lsLvl : sysDiv_reg[1];
	assign wdtOn  = cfg_reg[`CFG_WDT_EN] & (state_reg != ST_DEEP) &
		!((state_reg == ST_IDLE_STOP) & !cfg_reg[`CFG_WDT_SUB]);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wdtClk <= 1'b0;
			subClk <= 1'b0;
		end else begin
			wdtClk <= wdtOn & wdtLvl;
			subClk <= lsOscEn & lsLvl;
		end
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	assign wrMode = regWr & (regAddr == `OFS_MODE);
	assign wrCfg  = regWr & (regAddr == `OFS_CFG);
	assign wrStat = regWr & (regAddr == `OFS_STAT);
	assign wrIrqS = regWr & (regAddr == `OFS_IRQS);
	assign wrIrqM = regWr & (regAddr == `OFS_IRQM);

	// Ready bits always show live oscillator state, writes to them are lost
	assign rdMux =
		(regAddr == `OFS_MODE)  ? {mode_reg[7:4], lsRdy, hsRdy, mode_reg[1:0]} :
		(regAddr == `OFS_CFG)   ? {2'h0, cfg_reg} :
		(regAddr == `OFS_STAT)  ? {6'h00, stat_reg} :
		(regAddr == `OFS_IRQS)  ? {5'h00, irqStat_reg} :
		(regAddr == `OFS_IRQM)  ? {5'h00, irqMask_reg} :
		(regAddr == `OFS_STATE) ? {5'h00, state_reg} : 8'h00;

	// Halt and timeout events win over a software clear in the same cycle
	always_comb begin
		stat_next = stat_reg;
		if (wrStat)
			stat_next = stat_reg & ~regWdata[1:0];
		if (haltTaken)
			stat_next[`STAT_TO] = 1'b0;
		if (haltTaken)
			stat_next[`STAT_PDF] = 1'b1;
		if (wdtTimeout)
			stat_next[`STAT_TO] = 1'b1;
	end

	assign wakeDone = (state_reg != ST_RUN) & (state_next == ST_RUN);
	assign evt = {wakeDone, lsRdy & ~lsRdyOld_reg, hsRdy & ~hsRdyOld_reg};
	assign irqStat_next = (irqStat_reg & ~(wrIrqS ? regWdata[2:0] : 3'h0)) | evt;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg    <= ST_RUN;
			mode_reg     <= `MODE_RST;
			cfg_reg      <= 6'(`CFG_RST);
			stat_reg     <= `STAT_RST;
			irqStat_reg  <= `IRQ_RST;
			irqMask_reg  <= `IRQ_RST;
			hsRdyOld_reg <= 1'b0;
			lsRdyOld_reg <= 1'b0;
			regRdata     <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (wrMode)
				mode_reg <= {regWdata[7:4], 2'h0, regWdata[1:0]};
			if (wrCfg)
				cfg_reg <= regWdata[5:0];
			if (wrIrqM)
				irqMask_reg <= regWdata[2:0];
			stat_reg     <= stat_next;
			irqStat_reg  <= irqStat_next;
			hsRdyOld_reg <= hsRdy;
			lsRdyOld_reg <= lsRdy;
			regRdata     <= regRd ? rdMux : 8'h00;
		end
	end

	assign irq = |(irqStat_reg & irqMask_reg);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_halt_idle_stop: assert property (
		haltTaken && mode_reg[`MODE_IDLE] && !cfg_reg[`CFG_KEEP]
		|=> state_reg == ST_IDLE_STOP ##1 !cpuRun)
		else $error("halt did not enter stopped idle");

	a_wdt_gate_idle: assert property (
		state_reg == ST_IDLE_STOP && !cfg_reg[`CFG_WDT_SUB] |=> !wdtClk)
		else $error("watchdog clock ran in stopped idle");

	a_halt_idle_run: assert property (
		haltTaken && mode_reg[`MODE_IDLE] && cfg_reg[`CFG_KEEP]
		|=> state_reg == ST_IDLE_RUN && sysRun && !cpuRun)
		else $error("halt did not enter running idle");

	a_wdt_idle_run: assert property (
		state_reg == ST_IDLE_RUN && cfg_reg[`CFG_WDT_EN] |-> wdtOn)
		else $error("watchdog gated in running idle");

	a_hs_off_slow: assert property (
		state_reg == ST_RUN && selSrc == 3'h0 && !gate_reg |-> !hsOscEn)
		else $error("fast oscillator left on for slow clock");

	a_ls_ready_deep: assert property (
		state_reg == ST_DEEP && $past(state_reg == ST_DEEP) |-> !lsRdy)
		else $error("slow ready high in deep stop");

	a_sleep_vdet: assert property (
		haltTaken && !mode_reg[`MODE_IDLE] && cfg_reg[`CFG_VDET]
		|=> state_reg == ST_STOP_SUB)
		else $error("deep stop entered with detector on");

	a_deep_no_fast: assert property (
		state_reg == ST_DEEP && wakeReq |=> state_reg == ST_WAKE)
		else $error("quick wake used from deep stop");

	a_pdf_on_halt: assert property (
		haltTaken && !wdtTimeout |=> stat_reg == 2'h1)
		else $error("halt flags not updated");

	a_fast_switch: assert property (
		state_reg == ST_FAST && hsRdy |=> state_reg == ST_RUN ##1 wantSrc == selSrc)
		else $error("quick wake did not hand over to crystal");
endmodule : clk_power_ctrl
`default_nettype wire

// file: clk_power_ctrl_test.sv
// Self-checking testbench for the clock and power-mode controller
`timescale 1ns/100ps
`default_nettype none
`include "clk_params.svh"
module clk_power_ctrl_test
	import clk_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       clk_sys        = 1'b0;
	logic       nrst           = 1'b0;
	logic [7:0] regAddr        = 8'h00;
	logic [7:0] regWdata       = 8'h00;
	logic       regWr          = 1'b0;
	logic       regRd          = 1'b0;
	logic       haltReq        = 1'b0;
	logic       wakeReq        = 1'b0;
	logic       wdtTimeout     = 1'b0;
	wire  [7:0] regRdata;
	wire  [2:0] pwrState;
	wire        hsOscPin;
	wire        lsOscPin;
	wire        sysClk;
	wire        wdtClk;
	wire        cpuRun;
	wire        hsOscEn;
	wire        lsOscEn;
	wire        irq;
	wire        subClk;
	int         fails          = 0;
	int         samplesChecked = 0;
	int         cycles         = 0;
	int         sysRises       = 0;
	int         wdtRises       = 0;
	int         subRises       = 0;

	always #50 clk_sys = ~clk_sys;
	always @(posedge sysClk) sysRises++;
	always @(posedge wdtClk) wdtRises++;
	always @(posedge subClk) subRises++;

	clk_power_ctrl clk_power_ctrl_i (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.haltReq(haltReq), .wakeReq(wakeReq), .wdtTimeout(wdtTimeout),
		.hsOscPin(hsOscPin), .lsOscPin(lsOscPin), .sysClk(sysClk), .wdtClk(wdtClk),
		.subClk(subClk), .cpuRun(cpuRun), .hsOscEn(hsOscEn), .lsOscEn(lsOscEn),
		.pwrState(pwrState), .irq(irq));
	osc_model osc_model_i (.hsOscEn(hsOscEn), .lsOscEn(lsOscEn), .hsOscPin(hsOscPin),
		.lsOscPin(lsOscPin));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run;
		if (fails == 0 && samplesChecked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samplesChecked++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rng(input string what, input int lo, input int hi, input int got);
		samplesChecked++;
		if (got < lo || got > hi) begin
			fails++;
			$display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : rng

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask : rd

	// Select 0 halts, 1 wakes, 2 raises a watchdog timeout
	task automatic pulse(input int sel);
		@(posedge clk_sys);
		haltReq <= (sel == 0);
		wakeReq <= (sel == 1);
		wdtTimeout <= (sel == 2);
		@(posedge clk_sys);
		haltReq <= 1'b0;
		wakeReq <= 1'b0;
		wdtTimeout <= 1'b0;
		#1;
	endtask : pulse

	task automatic wait_state(input logic [2:0] st, input int lim);
		int n;
		n = 0;
		while (pwrState !== st && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("state", {5'h00, st}, {5'h00, pwrState});
	endtask : wait_state

	task automatic run_halt(input logic [7:0] cfg, input logic [7:0] mode,
		input logic [2:0] st, input logic hs, input int wLo, input int wHi,
		input logic [2:0] wst);
		logic [7:0] d;
		wr(`OFS_CFG, cfg);
		wr(`OFS_MODE, mode);
		pulse(2);
		pulse(0);
		chk("halt state", {5'h00, st}, {5'h00, pwrState});
		chk("cpu run", 8'h00, {7'h00, cpuRun});
		chk("slow enable", {7'h00, st != ST_DEEP}, {7'h00, lsOscEn});
		pulse(0);
		chk("second halt", {5'h00, st}, {5'h00, pwrState});
		// The fast oscillator is held until the clock gate has closed on a low phase
		cyc(20);
		chk("fast enable", {7'h00, hs}, {7'h00, hsOscEn});
		rd(`OFS_MODE, d);
		chk("ready bits", {4'h0, st != ST_DEEP, hs, 2'h0}, d & 8'h0C);
		rd(`OFS_STAT, d);
		chk("status", 8'h01, d);
		wdtRises = 0;
		subRises = 0;
		cyc(200);
		rng("watchdog clock", wLo, wHi, wdtRises);
		rng("sub clock", (st == ST_DEEP) ? 0 : 1, (st == ST_DEEP) ? 0 : 200, subRises);
		pulse(1);
		chk("wake state", {5'h00, wst}, {5'h00, pwrState});
		wait_state(ST_RUN, 8000);
		chk("cpu resumed", 8'h01, {7'h00, cpuRun});
		chk("wake irq", 8'h01, {7'h00, irq});
		wr(`OFS_IRQS, 8'h07);
		wr(`OFS_STAT, 8'h03);
		chk("irq cleared", 8'h00, {7'h00, irq});
	endtask : run_halt

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// The ceiling sits well above the longest expected run of crystal start-ups
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			complete_run();
		end
	end

	initial begin
		logic [7:0] d;
		int         k;
		int         div;
		cyc(4);
		nrst <= 1'b1;
		rd(`OFS_MODE, d);
		chk("mode reset", 8'h03, d & 8'hF7);
		cyc(5700);
		rd(`OFS_MODE, d);
		chk("crystal early", 8'h0B, d);
		for (k = 0; k < 400 && d[2] !== 1'b1; k++) rd(`OFS_MODE, d);
		chk("crystal ready", 8'h0F, d);
		rd(`OFS_IRQS, d);
		chk("irq status", 8'h03, d);
		wr(`OFS_IRQM, 8'h01);
		chk("irq masked in", 8'h01, {7'h00, irq});
		wr(`OFS_IRQS, 8'h01);
		chk("irq w1c", 8'h00, {7'h00, irq});
		rd(`OFS_IRQS, d);
		chk("irq left", 8'h02, d);
		wr(8'h06, 8'hFF);
		rd(8'h06, d);
		chk("unmapped", 8'h00, d);
		rd(`OFS_CFG, d);
		chk("cfg kept", 8'h00, d);
		wr(`OFS_IRQM, 8'h04);
		wr(`OFS_MODE, 8'h13);
		rd(`OFS_MODE, d);
		chk("mode readback", 8'h1F, d);
		wr(`OFS_CFG, 8'h20);
		for (k = 0; k < 9; k++) begin
			div = (k == 8) ? 1 : (1 << (8 - k));
			wr(`OFS_MODE, (k == 8) ? 8'h03 : {k[2:0], 5'h02});
			cyc(800);
			chk("fast enable", {7'h00, k > 1}, {7'h00, hsOscEn});
			sysRises = 0;
			cyc(1920);
			div = (k < 2) ? 137 : 320 / div;
			rng("sysclk rate", div - 1, div + 1, sysRises);
		end
		run_halt(8'h24, 8'h03, ST_IDLE_STOP, 1'b0, 0, 0, ST_WAKE);
		run_halt(8'h2C, 8'h13, ST_IDLE_STOP, 1'b0, 1, 200, ST_WAKE);
		run_halt(8'h04, 8'h13, ST_IDLE_STOP, 1'b0, 0, 0, ST_FAST);
		run_halt(8'h25, 8'h03, ST_IDLE_RUN, 1'b1, 1, 200, ST_RUN);
		run_halt(8'h2D, 8'h03, ST_IDLE_RUN, 1'b1, 1, 200, ST_RUN);
		run_halt(8'h00, 8'h11, ST_DEEP, 1'b0, 0, 0, ST_WAKE);
		run_halt(8'h02, 8'h11, ST_STOP_SUB, 1'b0, 0, 0, ST_FAST);
		run_halt(8'h2C, 8'h11, ST_STOP_SUB, 1'b0, 1, 200, ST_WAKE);
		complete_run();
	end
endmodule : clk_power_ctrl_test
`default_nettype wire

// file: osc_level_sync.sv
// Three-stage synchroniser for an oscillator pin with rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module osc_level_sync (
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	logic lvl_next;

	// Level changes only once the second and third stages agree
	assign lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
	assign level    = lvl_reg;
	assign rise     = lvl_next & ~lvl_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			s1_reg  <= pinIn;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end
endmodule : osc_level_sync
`default_nettype wire

// file: osc_model.sv
// Behavioural model of the fast and slow oscillators feeding the controller
`timescale 1ns/100ps
`default_nettype none
module osc_model #(
	parameter int HS_HALF = 300,
	parameter int LS_HALF = 700
) (
	input  wire logic hsOscEn,
	input  wire logic lsOscEn,
	output logic      hsOscPin,
	output logic      lsOscPin
);
	// ----------------------------------------
	// Pin generators
	// ----------------------------------------
	// A disabled oscillator stands low, so a stopped source never looks alive
	logic hsQ = 1'b0;
	logic lsQ = 1'b0;
	assign hsOscPin = hsQ;
	assign lsOscPin = lsQ;
	always begin
		#(HS_HALF);
		hsQ = hsOscEn ? ~hsQ : 1'b0;
	end
	always begin
		#(LS_HALF);
		lsQ = lsOscEn ? ~lsQ : 1'b0;
	end
endmodule : osc_model
`default_nettype wire

// file: osc_ready_timer.sv
// Counts oscillator edges after enable and raises a ready flag
`timescale 1ns/100ps
`default_nettype none
module osc_ready_timer #(
	parameter int W = 11
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         run,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	output logic              ready
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         rdy_next;

	// A stopped oscillator forgets its progress and starts over
	assign rdy_next = run & (cnt_reg >= limit);
	assign cnt_next = !run ? '0 : (tick & !rdy_next) ? W'(cnt_reg + 1'b1) : cnt_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
			ready   <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			ready   <= rdy_next;
		end
	end
endmodule : osc_ready_timer
`default_nettype wire
